// ===== hdl/lsce_consts.svh
// Offsets, field positions, reset values, opcodes and cycle counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef LSCE_CONSTS_SVH
`define LSCE_CONSTS_SVH

// ******************************************
// Register byte offsets and data memory select
// ******************************************
`define LSCE_A_CTRL     12'h000
`define LSCE_A_INSTR    12'h004
`define LSCE_A_PC       12'h008
`define LSCE_A_SP       12'h00c
`define LSCE_A_FLAGS    12'h010
`define LSCE_RAM_SEL    2'h1

// ******************************************
// Control fields
// ******************************************
`define LSCE_CTRL_GO    0
`define LSCE_CTRL_DONE  1
`define LSCE_CTRL_BAD   2

// ******************************************
// Reset values and responses
// ******************************************
`define LSCE_PC_RST     16'h0000
`define LSCE_SP_RST     8'h00
`define LSCE_RESP_OKAY  2'h0
`define LSCE_RESP_SLV   2'h2

// ******************************************
// Opcodes, lengths and cycle counts
// ******************************************
`define LSCE_OP_AND     8'h22
`define LSCE_OP_ASL     8'h29
`define LSCE_OP_ASR     8'h2a
`define LSCE_OP_CALL    8'h47
`define LSCE_LEN_AND    16'h0003
`define LSCE_LEN_SH     16'h0002
`define LSCE_CYC_AND    5'h11
`define LSCE_CYC_SH     5'h0f
`define LSCE_CYC_CALL   5'h11
`define LSCE_STEP_0     5'h00
`define LSCE_STEP_1     5'h01
`define LSCE_STEP_2     5'h02
`define LSCE_STEP_3     5'h03

`endif

// ===== hdl/lsce_pkg.sv
// Types shared by the execution block and its data memory.
// Assumes nothing of its surroundings.
package lsce_pkg;

  typedef enum logic {
    LSCE_IDLE = 1'b0,
    LSCE_RUN  = 1'b1
  } lsce_state_t;

  typedef enum logic [1:0] {
    LSCE_AND  = 2'b00,
    LSCE_ASL  = 2'b01,
    LSCE_ASR  = 2'b10,
    LSCE_CALL = 2'b11
  } lsce_op_t;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic result_null;
  } lsce_flags_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsce_ram_req_t;

endpackage

// ===== hdl/lsce_ram.sv
// Data memory of 256 bytes, also holding the system stack.
// Assumes one request per cycle; read data appear one cycle later.
`timescale 1ns/1ps
module lsce_ram (
  // Clock
  input  wire logic                   clk,
  // Request and read data
  input  wire lsce_pkg::lsce_ram_req_t req,
  output logic [7:0]                  rd_ff
);

  logic [7:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    rd_ff <= mem[req.addr];
  end

endmodule

// ===== hdl/lsce_top.sv
// Executes AND, shift left, shift right and call over a byte data memory.
// Assumes an AXI4-Lite master on CORE_CLK and software-loaded instructions.
`timescale 1ns/1ps
`include "lsce_consts.svh"
module lsce_top (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // Write address and data
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // Write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // Read address and data
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // ******************************************
  // Declarations
  // ******************************************
  lsce_pkg::lsce_state_t   state_ff;
  lsce_pkg::lsce_op_t      op_ff;
  lsce_pkg::lsce_op_t      nxt_op;
  lsce_pkg::lsce_flags_t   flags_ff;
  lsce_pkg::lsce_ram_req_t ram_req;
  lsce_pkg::lsce_ram_req_t exe_req;
  logic        aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
  logic        arready_ff, rvalid_ff, rerr_ff, done_ff, bad_ff;
  logic [11:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff, rd_st_ff;
  logic [23:0] instr_ff;
  logic [15:0] pc_ff;
  logic [7:0]  sp_ff, dst_val_ff, src_val_ff, ram_rd;
  logic [4:0]  cnt_ff;
  logic [31:0] wr_new;

  // ******************************************
  // Write channel decode
  // ******************************************
  wire run         = state_ff == lsce_pkg::LSCE_RUN;
  wire aw_fire     = AWVALID & awready_ff;
  wire w_fire      = WVALID & wready_ff;
  wire wr_do       = aw_hold_ff & w_hold_ff & ~bvalid_ff & (rd_st_ff != 2'h1);
  wire nxt_aw_hold = aw_fire | (aw_hold_ff & ~wr_do);
  wire nxt_w_hold  = w_fire | (w_hold_ff & ~wr_do);
  wire wa_ram      = awaddr_ff[11:10] == `LSCE_RAM_SEL;
  wire wa_ctrl     = awaddr_ff == `LSCE_A_CTRL;
  wire wa_instr    = awaddr_ff == `LSCE_A_INSTR;
  wire wa_pc       = awaddr_ff == `LSCE_A_PC;
  wire wa_sp       = awaddr_ff == `LSCE_A_SP;
  wire wa_flags    = awaddr_ff == `LSCE_A_FLAGS;
  wire wa_map      = wa_ram | wa_ctrl | wa_instr | wa_pc | wa_sp | wa_flags;
  wire wr_err      = ~wa_map | (run & ~wa_ctrl);
  wire wr_ok       = wr_do & ~wr_err;
  wire [31:0] wr_old = wa_instr ? {8'h00, instr_ff} :
                       wa_pc    ? {16'h0000, pc_ff} :
                       wa_sp    ? {24'h000000, sp_ff} :
                       wa_flags ? {29'h00000000, flags_ff} : 32'h00000000;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wr_new[8*g +: 8] = wstrb_ff[g] ? wdata_ff[8*g +: 8] : wr_old[8*g +: 8];
    end
  endgenerate

  wire ctl_wr   = wr_ok & wa_ctrl & wstrb_ff[0];
  wire go       = ctl_wr & wdata_ff[`LSCE_CTRL_GO];
  wire clr_done = ctl_wr & wdata_ff[`LSCE_CTRL_DONE];
  wire clr_bad  = ctl_wr & wdata_ff[`LSCE_CTRL_BAD];

  // ******************************************
  // Instruction decode
  // ******************************************
  wire [7:0]  opc      = instr_ff[7:0];
  wire [7:0]  dst_a    = instr_ff[15:8];
  wire [7:0]  src_a    = instr_ff[23:16];
  wire [15:0] label    = {instr_ff[15:8], instr_ff[23:16]};
  wire        op_known = (opc == `LSCE_OP_AND) | (opc == `LSCE_OP_ASL) |
                         (opc == `LSCE_OP_ASR) | (opc == `LSCE_OP_CALL);
  assign nxt_op = (opc == `LSCE_OP_CALL) ? lsce_pkg::LSCE_CALL :
                  (opc == `LSCE_OP_ASL)  ? lsce_pkg::LSCE_ASL :
                  (opc == `LSCE_OP_ASR)  ? lsce_pkg::LSCE_ASR : lsce_pkg::LSCE_AND;
  wire start   = go & ~run & op_known;
  wire bad_op  = go & ~run & ~op_known;
  wire is_call = op_ff == lsce_pkg::LSCE_CALL;
  wire is_and  = op_ff == lsce_pkg::LSCE_AND;
  wire is_asl  = op_ff == lsce_pkg::LSCE_ASL;
  wire is_asr  = op_ff == lsce_pkg::LSCE_ASR;

  // ******************************************
  // Execution sequence
  // ******************************************
  wire [4:0] cyc_last = is_and  ? `LSCE_CYC_AND - 5'h01 :
                        is_call ? `LSCE_CYC_CALL - 5'h01 :
                                  `LSCE_CYC_SH - 5'h01;
  wire fin = run & (cnt_ff == cyc_last);
  wire s0  = run & (cnt_ff == `LSCE_STEP_0);
  wire s1  = run & (cnt_ff == `LSCE_STEP_1);
  wire s2  = run & (cnt_ff == `LSCE_STEP_2);
  wire s3  = run & (cnt_ff == `LSCE_STEP_3);
  wire [7:0] res = is_and ? (dst_val_ff & src_val_ff) :
                   is_asl ? {dst_val_ff[6:0], 1'b0} :
                            {1'b0, dst_val_ff[7:1]};
  wire dst_msb = dst_val_ff[7];
  wire dst_lsb = dst_val_ff[0];
  wire [15:0] pc_len = is_and ? `LSCE_LEN_AND : `LSCE_LEN_SH;

  assign exe_req.we    = is_call ? (s1 | s2) : s3;
  assign exe_req.addr  = is_call ? (s1 ? sp_ff : sp_ff + 8'h01) :
                         (s1 & is_and) ? src_a : dst_a;
  assign exe_req.wdata = is_call ? (s1 ? pc_ff[15:8] : pc_ff[7:0]) : res;
  assign ram_req = run ? exe_req :
                   (rd_st_ff == 2'h1) ? {1'b0, araddr_ff[9:2], 8'h00} :
                   {wr_ok & wa_ram & wstrb_ff[0], awaddr_ff[9:2], wdata_ff[7:0]};

  lsce_ram u_ram (
    .clk   (CORE_CLK),
    .req   (ram_req),
    .rd_ff (ram_rd)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_ff <= lsce_pkg::LSCE_IDLE;
      op_ff    <= lsce_pkg::LSCE_AND;
      cnt_ff   <= 5'h00;
      done_ff  <= 1'b0;
      bad_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        lsce_pkg::LSCE_IDLE: begin
          if (start) begin
            state_ff <= lsce_pkg::LSCE_RUN;
            op_ff    <= nxt_op;
          end
          cnt_ff <= 5'h00;
        end
        lsce_pkg::LSCE_RUN: begin
          if (fin) begin
            state_ff <= lsce_pkg::LSCE_IDLE;
          end
          cnt_ff <= cnt_ff + 5'h01;
        end
      endcase
      done_ff <= fin | (done_ff & ~clr_done);
      bad_ff  <= bad_op | (bad_ff & ~clr_bad);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      dst_val_ff <= 8'h00;
      src_val_ff <= 8'h00;
    end else begin
      if (s1) begin
        dst_val_ff <= ram_rd;
      end
      if (s2) begin
        src_val_ff <= ram_rd;
      end
    end
  end

  // ******************************************
  // Software-visible state
  // ******************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      instr_ff <= 24'h000000;
      pc_ff    <= `LSCE_PC_RST;
      sp_ff    <= `LSCE_SP_RST;
      flags_ff <= 3'h0;
    end else begin
      if (wr_ok & wa_instr) begin
        instr_ff <= wr_new[23:0];
      end
      if (wr_ok & wa_pc) begin
        pc_ff <= wr_new[15:0];
      end else if (s3 & is_call) begin
        pc_ff <= label;
      end else if (fin & ~is_call) begin
        pc_ff <= pc_ff + pc_len;
      end
      if (wr_ok & wa_sp) begin
        sp_ff <= wr_new[7:0];
      end else if (s0 & is_call) begin
        sp_ff <= sp_ff - 8'h02;
      end
      if (wr_ok & wa_flags) begin
        flags_ff <= wr_new[2:0];
      end else if (s3 & ~is_call) begin
        flags_ff.result_null <= res == 8'h00;
        if (is_asl) begin
          flags_ff.overflow <= dst_msb;
        end
        if (is_asr) begin
          flags_ff.underflow <= dst_lsb;
        end
      end
    end
  end

  // ******************************************
  // AXI4-Lite write path
  // ******************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `LSCE_RESP_OKAY;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold;
      wready_ff  <= ~nxt_w_hold;
      if (aw_fire) begin
        awaddr_ff <= AWADDR[11:0];
      end
      if (w_fire) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_err ? `LSCE_RESP_SLV : `LSCE_RESP_OKAY;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ******************************************
  // AXI4-Lite read path
  // ******************************************
  wire ar_fire  = ARVALID & arready_ff;
  wire ra_ram   = araddr_ff[11:10] == `LSCE_RAM_SEL;
  wire ra_ctrl  = araddr_ff == `LSCE_A_CTRL;
  wire ra_instr = araddr_ff == `LSCE_A_INSTR;
  wire ra_pc    = araddr_ff == `LSCE_A_PC;
  wire ra_sp    = araddr_ff == `LSCE_A_SP;
  wire ra_flags = araddr_ff == `LSCE_A_FLAGS;
  wire ra_map   = ra_ram | ra_ctrl | ra_instr | ra_pc | ra_sp | ra_flags;
  wire [31:0] rd_val = ra_ram   ? {24'h000000, ram_rd} :
                       ra_ctrl  ? {29'h00000000, bad_ff, done_ff, run} :
                       ra_instr ? {8'h00, instr_ff} :
                       ra_pc    ? {16'h0000, pc_ff} :
                       ra_sp    ? {24'h000000, sp_ff} :
                       ra_flags ? {29'h00000000, flags_ff} : 32'h00000000;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      arready_ff <= 1'b1;
      rd_st_ff   <= 2'h0;
      araddr_ff  <= 12'h000;
      rerr_ff    <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `LSCE_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        araddr_ff  <= ARADDR[11:0];
        arready_ff <= 1'b0;
        rd_st_ff   <= 2'h1;
      end else if (rd_st_ff == 2'h1) begin
        rerr_ff  <= ~ra_map | (ra_ram & run);
        rd_st_ff <= 2'h2;
      end else if (rd_st_ff == 2'h2) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rerr_ff ? 32'h00000000 : rd_val;
        rresp_ff  <= rerr_ff ? `LSCE_RESP_SLV : `LSCE_RESP_OKAY;
        rd_st_ff  <= 2'h3;
      end else if ((rd_st_ff == 2'h3) & RREADY) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
        rd_st_ff   <= 2'h0;
      end
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY  = wready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;

  // ******************************************
  // Assertions
  // ******************************************
  property p_and_data;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_and |-> ##3 ram_req.we && ram_req.addr == dst_a &&
      ram_req.wdata == ($past(ram_rd, 2) & $past(ram_rd, 1));
  endproperty
  a_and_data: assert property (p_and_data) else $error("AND result wrong");

  property p_and_len;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_and |-> ##16 run ##1 !run && done_ff;
  endproperty
  a_and_len: assert property (p_and_len) else $error("AND length wrong");

  property p_and_flags;
    @(posedge CORE_CLK) disable iff (!RST_B)
    s3 && is_and |=> flags_ff.result_null == ($past(res) == 8'h00) &&
      $stable(flags_ff.overflow) && $stable(flags_ff.underflow);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("AND flags wrong");

  property p_asl_data;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_asl |-> ##3 ram_req.we && ram_req.addr == dst_a &&
      ram_req.wdata == 8'($past(ram_rd, 2) << 1);
  endproperty
  a_asl_data: assert property (p_asl_data) else $error("Left shift wrong");

  property p_asl_flags;
    @(posedge CORE_CLK) disable iff (!RST_B)
    s3 && is_asl |=> flags_ff.overflow == $past(dst_msb) &&
      flags_ff.result_null == ($past(res) == 8'h00) && $stable(flags_ff.underflow);
  endproperty
  a_asl_flags: assert property (p_asl_flags) else $error("Left shift flags wrong");

  property p_asr_data;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_asr |-> ##3 ram_req.we &&
      ram_req.wdata == ($past(ram_rd, 2) >> 1) ##11 run ##1 !run;
  endproperty
  a_asr_data: assert property (p_asr_data) else $error("Right shift wrong");

  property p_asr_flags;
    @(posedge CORE_CLK) disable iff (!RST_B)
    s3 && is_asr |=> flags_ff.underflow == $past(dst_lsb) &&
      flags_ff.result_null == ($past(res) == 8'h00) && $stable(flags_ff.overflow);
  endproperty
  a_asr_flags: assert property (p_asr_flags) else $error("Right shift flags wrong");

  property p_call_sp;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_call |=> sp_ff == $past(sp_ff) - 8'h02 ##0
      ram_req.we && ram_req.addr == sp_ff;
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("Call stack pointer wrong");

  property p_call_pc;
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run) && is_call |-> ##17 !run && pc_ff == label &&
      flags_ff == $past(flags_ff, 17);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("Call target wrong");

  property p_push;
    @(posedge CORE_CLK) disable iff (!RST_B)
    s1 && is_call |-> ram_req.wdata == pc_ff[15:8] ##1
      ram_req.we && ram_req.addr == sp_ff + 8'h01 && ram_req.wdata == pc_ff[7:0];
  endproperty
  a_push: assert property (p_push) else $error("Pushed counter wrong");

endmodule

// ===== dv/lsce_host.sv
// AXI4-Lite master standing in for software on the register bus.
// Assumes one clock; the caller ends hangs with its own watchdog.
`timescale 1ns/1ps
module lsce_host (
  // Clock
  input  wire logic        clk,
  // Write channels
  output logic [31:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [31:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ****************************************
  // Write: address and data together
  // ****************************************
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic b;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      b = (bvalid === 1'b1);
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // ****************************************
  // Read
  // ****************************************
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      v = (rvalid === 1'b1);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the execution block.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
`include "lsce_consts.svh"
module tb;
  logic        core_clk, rst_b;
  logic [31:0] awaddr, wdata, araddr, rdata, rdv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          num_errors, check_count;

  lsce_top DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  lsce_host host (.clk(core_clk), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    host.wr(a, d, 4'hf, resp);
  endtask
  task automatic r(input logic [31:0] a);
    host.rd(a, rdv, resp);
  endtask
  function automatic logic [31:0] ram(input logic [7:0] i);
    return 32'h0000_0400 + {22'h0, i, 2'b00};
  endfunction
  task automatic exec(input logic [23:0] ins, input int n);
    w(32'h0000_0004, {8'h00, ins});
    w(32'h0000_0000, 32'h0000_0003);
    r(ram(8'h00));
    chk({30'h0, resp}, 32'h0000_0002);
    repeat (n - 10) @(posedge core_clk);
    r(32'h0000_0000);
    chk(rdv & 32'h1, 32'h1);
    repeat (4) @(posedge core_clk);
    r(32'h0000_0000);
    chk(rdv & 32'h7, 32'h2);
  endtask
  task automatic expect_rd(input logic [31:0] a, input logic [31:0] e);
    r(a);
    chk(rdv, e);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    expect_rd(32'h0000_0000, 32'h0);
    expect_rd(32'h0000_0004, 32'h0);
    expect_rd(32'h0000_0008, 32'h0);
    expect_rd(32'h0000_000c, 32'h0);
    expect_rd(32'h0000_0010, 32'h0);
    expect_rd(32'h0000_0020, 32'h0);
    chk({30'h0, resp}, 32'h2);
    w(32'h0000_0020, 32'h1);
    chk({30'h0, resp}, 32'h2);
  endtask
  task automatic t_shift;
    w(ram(8'h14), 32'h96);
    w(ram(8'h15), 32'h55);
    exec({8'h00, 8'h14, `LSCE_OP_ASL}, 15);
    expect_rd(ram(8'h14), 32'h2c);
    expect_rd(32'h0000_0010, 32'h2);
    expect_rd(32'h0000_0008, 32'h2);
    exec({8'h00, 8'h15, `LSCE_OP_ASR}, 15);
    expect_rd(ram(8'h15), 32'h2a);
    expect_rd(32'h0000_0010, 32'h6);
    expect_rd(32'h0000_0008, 32'h4);
  endtask
  task automatic t_and;
    w(ram(8'h14), 32'hf0);
    w(ram(8'h0b), 32'h55);
    w(ram(8'h16), 32'h0f);
    exec({8'h0b, 8'h14, `LSCE_OP_AND}, 17);
    expect_rd(ram(8'h14), 32'h50);
    expect_rd(ram(8'h0b), 32'h55);
    expect_rd(32'h0000_0010, 32'h6);
    expect_rd(32'h0000_0008, 32'h7);
    exec({8'h16, 8'h14, `LSCE_OP_AND}, 17);
    expect_rd(ram(8'h14), 32'h0);
    expect_rd(32'h0000_0010, 32'h7);
  endtask
  task automatic t_call;
    w(32'h0000_0008, 32'h0000_1234);
    exec({8'hc4, 8'h09, `LSCE_OP_CALL}, 17);
    expect_rd(32'h0000_000c, 32'h0000_00fe);
    expect_rd(ram(8'hfe), 32'h12);
    expect_rd(ram(8'hff), 32'h34);
    expect_rd(32'h0000_0008, 32'h0000_09c4);
    expect_rd(32'h0000_0010, 32'h7);
  endtask
  task automatic t_bad;
    w(32'h0000_0004, 32'h0);
    w(32'h0000_0000, 32'h3);
    expect_rd(32'h0000_0000, 32'h4);
    expect_rd(32'h0000_0008, 32'h0000_09c4);
    w(32'h0000_0000, 32'h4);
    expect_rd(32'h0000_0000, 32'h0);
  endtask
  task automatic t_busy;
    w(32'h0000_0004, {8'h00, 8'h15, `LSCE_OP_ASL});
    w(32'h0000_0000, 32'h0000_0003);
    w(32'h0000_0008, 32'h0000_5555);
    chk({30'h0, resp}, 32'h2);
    w(32'h0000_0000, 32'h0000_0001);
    chk({30'h0, resp}, 32'h0);
    repeat (20) @(posedge core_clk);
    expect_rd(ram(8'h15), 32'h54);
    expect_rd(32'h0000_0010, 32'h4);
    expect_rd(32'h0000_0008, 32'h0000_09c6);
    expect_rd(32'h0000_0000, 32'h2);
    host.wr(32'h0000_0008, 32'h0000_ab77, 4'h1, resp);
    expect_rd(32'h0000_0008, 32'h0000_0977);
    host.wr(ram(8'h15), 32'h0000_0011, 4'he, resp);
    expect_rd(ram(8'h15), 32'h54);
  endtask
  task automatic t_rerun;
    w(32'h0000_0004, {8'h0b, 8'h14, `LSCE_OP_AND});
    w(32'h0000_0000, 32'h0000_0003);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    expect_rd(32'h0000_0000, 32'h0);
    expect_rd(32'h0000_0004, 32'h0);
    expect_rd(32'h0000_0008, 32'h0);
    expect_rd(32'h0000_0010, 32'h0);
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_shift();
    t_and();
    t_call();
    t_bad();
    t_busy();
    t_rerun();
    end_sim();
  end
endmodule
